// *** rtl/ibpc_pkg.sv ***
// shared constants and types for the input bus pattern checker and its data source
package ibpc_pkg;
   // register map, indices on the serial control port
   localparam logic [4:0] IBPC_ADDR_CTRL  = 5'h01;
   localparam logic [4:0] IBPC_ADDR_ALARM = 5'h07;
   localparam logic [4:0] IBPC_ADDR_LOC   = 5'h08;
   localparam logic [4:0] IBPC_ADDR_KEY0  = 5'h09;
   localparam logic [4:0] IBPC_ADDR_KEY7  = 5'h10;
   // field positions
   localparam int IBPC_CTRL_EN_BIT  = 0;
   localparam int IBPC_ALARM_IO_BIT = 3;
   // reset values
   localparam logic [7:0] IBPC_KEY0_RST = 8'h7A;
   localparam logic [7:0] IBPC_KEYN_RST = 8'h00;
   localparam logic [7:0] IBPC_LOC_RST  = 8'h00;
   // link geometry
   localparam int IBPC_KEY_WORDS = 8;
   localparam int IBPC_BUS_W     = 8;
   // link clock made by the source: half period from the system clock rate
   localparam int IBPC_CLK_NS       = 40;
   localparam int IBPC_LINK_HALF_NS = 160;
   localparam int IBPC_HALF_CYC     = IBPC_LINK_HALF_NS / IBPC_CLK_NS;
   localparam logic [1:0] IBPC_DRIVE_PH  = 2'(IBPC_HALF_CYC / 2 - 1);
   localparam logic [1:0] IBPC_TOGGLE_PH = 2'(IBPC_HALF_CYC - 1);

   typedef enum logic [1:0] {
      IBPC_CHK_IDLE  = 2'b00,
      IBPC_CHK_ALIGN = 2'b01,
      IBPC_CHK_RUN   = 2'b11
   } ibpc_chk_st_t;

   typedef enum logic {
      IBPC_SRC_IDLE = 1'b0,
      IBPC_SRC_RUN  = 1'b1
   } ibpc_src_st_t;
endpackage

// *** rtl/ibpc_link_if.sv ***
// byte-wide double-edge link between the data source and the checker
`timescale 1ns/100ps
interface ibpc_link_if;
   logic       input_word_clock;
   logic       marker;
   logic [7:0] data;

   modport source (
      output input_word_clock,
      output marker,
      output data
   );
   modport checker_end (
      input input_word_clock,
      input marker,
      input data
   );
endinterface

// *** rtl/ibpc_checker.sv ***
// device end: double-edge bus capture, key compare, sticky error registers
`timescale 1ns/100ps
module ibpc_checker
   import ibpc_pkg::*;
(
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_b_i,
   // link from the data source
   ibpc_link_if.checker_end link,
   // serial control register port
   input  wire logic [4:0] cfg_addr_i,
   input  wire logic [7:0] cfg_wdata_i,
   input  wire logic       cfg_we_i,
   output logic      [7:0] cfg_rdata_o,
   // analog side
   input  wire logic       transmit_output_enable_i,
   output logic            analog_active_o,
   output logic            iface_alarm_o
);

   typedef struct packed {
      logic [9:0]      sync1;
      logic [9:0]      sync2;
      logic [9:0]      sync3;
      logic            clk_lvl;
      logic            mark_last;
      logic            test_en;
      logic [7:0]      err_loc;
      logic            alarm;
      logic [7:0][7:0] key;
      logic [2:0]      pos;
      ibpc_chk_st_t    st;
      logic [7:0]      rdata;
   } ibpc_chk_state_t;

   ibpc_chk_state_t q;
   ibpc_chk_state_t d;

   logic       clk_edge;
   logic       clk_rise;
   logic       mark_up;
   logic [7:0] word;
   logic [7:0] mism;

   always_comb begin
      d        = q;
      mism     = 8'h00;
      word     = q.sync3[7:0];
      clk_edge = 1'b0;
      clk_rise = 1'b0;
      mark_up  = 1'b0;

      // three-stage capture; first stage feeds only the second
      d.sync1 = {link.input_word_clock, link.marker, link.data};
      d.sync2 = q.sync1;
      d.sync3 = q.sync2;

      // a clock change counts once stages two and three agree
      if (q.sync2[9] == q.sync3[9] && q.sync3[9] != q.clk_lvl) begin
         clk_edge  = 1'b1;
         clk_rise  = q.sync3[9];
         d.clk_lvl = q.sync3[9];
      end

      // marker only looked at on rising edges
      if (clk_rise) begin
         d.mark_last = q.sync3[8];
         mark_up     = q.sync3[8] & ~q.mark_last;
      end

      if (!q.test_en) begin
         d.st  = IBPC_CHK_IDLE;
         d.pos = 3'h0;
      end else begin
         case (q.st)
            IBPC_CHK_IDLE: begin
               // a marker caught in the enable cycle still aligns
               if (mark_up) begin
                  mism  = word ^ q.key[0];
                  d.pos = 3'h1;
                  d.st  = IBPC_CHK_RUN;
               end else begin
                  d.st = IBPC_CHK_ALIGN;
               end
            end
            IBPC_CHK_ALIGN: begin
               // words ahead of the first marker are not checked
               if (mark_up) begin
                  mism  = word ^ q.key[0];
                  d.pos = 3'h1;
                  d.st  = IBPC_CHK_RUN;
               end
            end
            IBPC_CHK_RUN: begin
               if (mark_up) begin
                  // a later marker simply realigns to word zero
                  mism  = word ^ q.key[0];
                  d.pos = 3'h1;
               end else if (clk_edge) begin
                  mism  = word ^ q.key[q.pos];
                  d.pos = 3'(q.pos + 3'h1);
               end
            end
            default: begin
               d.st = IBPC_CHK_IDLE;
            end
         endcase
      end

      // register writes, address decode
      if (cfg_we_i) begin
         if (cfg_addr_i == IBPC_ADDR_CTRL) begin
            d.test_en = cfg_wdata_i[IBPC_CTRL_EN_BIT];
         end else if (cfg_addr_i == IBPC_ADDR_ALARM) begin
            d.alarm = cfg_wdata_i[IBPC_ALARM_IO_BIT];
         end else if (cfg_addr_i == IBPC_ADDR_LOC) begin
            d.err_loc = cfg_wdata_i;
         end else if (cfg_addr_i == IBPC_ADDR_KEY0) begin
            d.key[0] = cfg_wdata_i;
         end else if (cfg_addr_i == IBPC_ADDR_KEY0 + 5'h01) begin
            d.key[1] = cfg_wdata_i;
         end else if (cfg_addr_i == IBPC_ADDR_KEY0 + 5'h02) begin
            d.key[2] = cfg_wdata_i;
         end else if (cfg_addr_i == IBPC_ADDR_KEY0 + 5'h03) begin
            d.key[3] = cfg_wdata_i;
         end else if (cfg_addr_i == IBPC_ADDR_KEY0 + 5'h04) begin
            d.key[4] = cfg_wdata_i;
         end else if (cfg_addr_i == IBPC_ADDR_KEY0 + 5'h05) begin
            d.key[5] = cfg_wdata_i;
         end else if (cfg_addr_i == IBPC_ADDR_KEY0 + 5'h06) begin
            d.key[6] = cfg_wdata_i;
         end else if (cfg_addr_i == IBPC_ADDR_KEY7) begin
            d.key[7] = cfg_wdata_i;
         end
      end

      // set wins over a clear in the same cycle
      d.err_loc = d.err_loc | mism;
      d.alarm   = d.alarm | (|mism);

      // read data, registered one cycle behind the address
      if (cfg_addr_i == IBPC_ADDR_CTRL) begin
         d.rdata = {7'h00, q.test_en};
      end else if (cfg_addr_i == IBPC_ADDR_ALARM) begin
         d.rdata = {4'h0, q.alarm, 3'h0};
      end else if (cfg_addr_i == IBPC_ADDR_LOC) begin
         d.rdata = q.err_loc;
      end else if (cfg_addr_i == IBPC_ADDR_KEY0) begin
         d.rdata = q.key[0];
      end else if (cfg_addr_i == IBPC_ADDR_KEY0 + 5'h01) begin
         d.rdata = q.key[1];
      end else if (cfg_addr_i == IBPC_ADDR_KEY0 + 5'h02) begin
         d.rdata = q.key[2];
      end else if (cfg_addr_i == IBPC_ADDR_KEY0 + 5'h03) begin
         d.rdata = q.key[3];
      end else if (cfg_addr_i == IBPC_ADDR_KEY0 + 5'h04) begin
         d.rdata = q.key[4];
      end else if (cfg_addr_i == IBPC_ADDR_KEY0 + 5'h05) begin
         d.rdata = q.key[5];
      end else if (cfg_addr_i == IBPC_ADDR_KEY0 + 5'h06) begin
         d.rdata = q.key[6];
      end else if (cfg_addr_i == IBPC_ADDR_KEY7) begin
         d.rdata = q.key[7];
      end else begin
         d.rdata = 8'h00;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         q.sync1     <= 10'h000;
         q.sync2     <= 10'h000;
         q.sync3     <= 10'h000;
         q.clk_lvl   <= 1'b0;
         q.mark_last <= 1'b0;
         q.test_en   <= 1'b0;
         q.err_loc   <= IBPC_LOC_RST;
         q.alarm     <= 1'b0;
         q.key       <= {{(IBPC_KEY_WORDS - 1){IBPC_KEYN_RST}}, IBPC_KEY0_RST};
         q.pos       <= 3'h0;
         q.st        <= IBPC_CHK_IDLE;
         q.rdata     <= 8'h00;
      end else begin
         q <= d;
      end
   end

   assign cfg_rdata_o     = q.rdata;
   assign analog_active_o = transmit_output_enable_i & ~q.test_en;
   assign iface_alarm_o   = q.alarm;

endmodule

// *** rtl/ibpc_source.sv ***
// far end: makes the link clock and streams the key sequence on both edges
`timescale 1ns/100ps
module ibpc_source
   import ibpc_pkg::*;
(
   // clock and reset
   input  wire logic            clk_i,
   input  wire logic            rst_b_i,
   // user side
   input  wire logic            run_i,
   input  wire logic [7:0][7:0] key_i,
   input  wire logic [7:0]      flip_mask_i,
   output logic                 busy_o,
   // link to the checker
   ibpc_link_if.source          link
);

   typedef struct packed {
      logic [1:0]   phase;
      logic         lclk;
      logic         marker;
      logic [7:0]   data;
      logic [2:0]   idx;
      logic         first;
      ibpc_src_st_t st;
   } ibpc_src_state_t;

   ibpc_src_state_t q;
   ibpc_src_state_t d;

   always_comb begin
      d = q;
      case (q.st)
         IBPC_SRC_IDLE: begin
            d.lclk   = 1'b0;
            d.marker = 1'b0;
            if (run_i) begin
               d.st    = IBPC_SRC_RUN;
               d.phase = 2'h0;
               d.idx   = 3'h0;
               d.first = 1'b1;
            end
         end
         IBPC_SRC_RUN: begin
            d.phase = 2'(q.phase + 2'h1);
            // data changes mid half period, well away from the edge
            if (q.phase == IBPC_DRIVE_PH) begin
               d.data = key_i[q.idx] ^ flip_mask_i;
               d.idx  = 3'(q.idx + 3'h1);
               if (q.first && q.idx == 3'h0) begin
                  d.marker = 1'b1;
               end else if (q.idx == 3'h2) begin
                  // one marker per run is enough
                  d.marker = 1'b0;
                  d.first  = 1'b0;
               end
            end
            if (q.phase == IBPC_TOGGLE_PH) begin
               d.lclk = ~q.lclk;
               // stop only after a falling edge, next run starts on word zero
               if (q.lclk && !run_i) begin
                  d.st = IBPC_SRC_IDLE;
               end
            end
         end
         default: begin
            d.st = IBPC_SRC_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         q    <= '0;
         q.st <= IBPC_SRC_IDLE;
      end else begin
         q <= d;
      end
   end

   assign link.input_word_clock = q.lclk;
   assign link.marker           = q.marker;
   assign link.data             = q.data;
   assign busy_o                = (q.st == IBPC_SRC_RUN);

endmodule

// *** verification/ibpc_link_chk.sv ***
// wire-level assertions on the link between the data source and the checker
`timescale 1ns/100ps
module ibpc_link_chk (
   // system clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_b_i,
   // link signals
   input  wire logic       input_word_clock,
   input  wire logic       marker,
   input  wire logic [7:0] data
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   high_half_a: assert property ($rose(input_word_clock) |-> input_word_clock[*4] ##1 !input_word_clock)
      else $error("link clock high half not four cycles");
   low_half_a: assert property ($fell(input_word_clock) |-> !input_word_clock[*4])
      else $error("link clock low half shorter than four cycles");
   data_settled_a: assert property ($changed(input_word_clock) |-> data == $past(data, 2))
      else $error("bus word moved too close to a link clock edge");
   data_hold_a: assert property ($changed(input_word_clock) |=> $stable(data))
      else $error("bus word moved right after a link clock edge");
   marker_word0_a: assert property ($rose(marker) |-> !input_word_clock ##[1:3] $rose(input_word_clock))
      else $error("marker rise not followed by a rising link edge");
   marker_span_a: assert property ($rose(marker) |-> marker[*8] ##1 !marker)
      else $error("marker not held across exactly one rising edge");
endmodule

// *** verification/ibpc_tb.sv ***
// self-checking bench: source and checker joined by the link
`timescale 1ns/100ps
module ibpc_tb;
   import ibpc_pkg::*;
   logic            clk_i;
   logic            rst_b_i;
   logic [4:0]      cfg_addr;
   logic [7:0]      cfg_wdata;
   logic            cfg_we;
   logic [7:0]      cfg_rdata;
   logic            tx_en;
   logic            analog_active;
   logic            iface_alarm;
   logic            run;
   logic [7:0][7:0] key;
   logic [7:0]      flip;
   logic            busy;
   logic [7:0]      rnd;
   logic [7:0]      mask;
   logic [7:0][7:0] want;
   int              n_mismatch;
   int              checks;

   ibpc_link_if link ();
   ibpc_source ibpc_source_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .run_i(run), .key_i(key),
      .flip_mask_i(flip), .busy_o(busy), .link(link));
   ibpc_checker ibpc_checker_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .link(link), .cfg_addr_i(cfg_addr),
      .cfg_wdata_i(cfg_wdata), .cfg_we_i(cfg_we), .cfg_rdata_o(cfg_rdata),
      .transmit_output_enable_i(tx_en), .analog_active_o(analog_active), .iface_alarm_o(iface_alarm));
   ibpc_link_chk ibpc_link_chk_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .input_word_clock(link.input_word_clock),
      .marker(link.marker), .data(link.data));

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   // error bits left by whole sequences of sent words against the key
   function automatic logic [7:0] exp_loc(input logic [7:0][7:0] sent, input logic [7:0][7:0] ref_key);
      logic [7:0] acc;
      acc = 8'h00;
      for (int n = 0; n < IBPC_KEY_WORDS; n++) acc = acc | (sent[n] ^ ref_key[n]);
      return acc;
   endfunction

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk_i);
      cfg_addr  <= a;
      cfg_wdata <= d;
      cfg_we    <= 1'b1;
      @(posedge clk_i);
      cfg_we    <= 1'b0;
   endtask

   task automatic rd(input logic [4:0] a, input logic [7:0] exp);
      @(posedge clk_i);
      cfg_addr <= a;
      repeat (2) @(posedge clk_i);
      #1 cmp($sformatf("reg %h", a), exp, cfg_rdata);
   endtask

   // one sequence is eight edges of four clocks each
   task automatic stream(input int seqs, input logic [7:0] m);
      int i;
      @(posedge clk_i);
      flip <= m;
      run  <= 1'b1;
      repeat (seqs * 32) @(posedge clk_i);
      run  <= 1'b0;
      for (i = 0; i < 20 && busy !== 1'b0; i++) @(posedge clk_i);
      if (busy !== 1'b0) begin
         n_mismatch++;
         give_verdict();
      end
      repeat (8) @(posedge clk_i);
   endtask

   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   initial begin
      rst_b_i    = 1'b0;
      cfg_addr   = 5'h00;
      cfg_wdata  = 8'h00;
      cfg_we     = 1'b0;
      tx_en      = 1'b1;
      run        = 1'b0;
      key        = '0;
      flip       = 8'h00;
      n_mismatch = 0;
      checks     = 0;
      rnd        = 8'h2B;
      repeat (10) @(posedge clk_i);
      rst_b_i <= 1'b1;
      rd(IBPC_ADDR_KEY0, IBPC_KEY0_RST);
      for (int n = 1; n < 8; n++) rd(IBPC_ADDR_KEY0 + 5'(n), IBPC_KEYN_RST);
      rd(IBPC_ADDR_LOC, 8'h00);
      rd(IBPC_ADDR_ALARM, 8'h00);
      cmp("analog", 8'h01, {7'h00, analog_active});
      for (int n = 0; n < 8; n++) begin
         rnd = lfsr(rnd);
         key[n] <= rnd;
         wr(IBPC_ADDR_KEY0 + 5'(n), rnd);
         rd(IBPC_ADDR_KEY0 + 5'(n), rnd);
      end
      // errors sent while test mode is off must leave no trace
      stream(2, 8'hFF);
      wr(IBPC_ADDR_CTRL, 8'h01);
      #1 cmp("analog", 8'h00, {7'h00, analog_active});
      rd(IBPC_ADDR_LOC, 8'h00);
      rd(IBPC_ADDR_CTRL, 8'h01);
      stream(100, 8'h00);
      rd(IBPC_ADDR_LOC, 8'h00);
      rd(IBPC_ADDR_ALARM, 8'h00);
      mask = lfsr(rnd);
      stream(2, mask);
      rd(IBPC_ADDR_LOC, mask);
      rd(IBPC_ADDR_ALARM, 8'h08);
      cmp("alarm", 8'h01, {7'h00, iface_alarm});
      stream(2, 8'h00);
      rd(IBPC_ADDR_LOC, mask);
      wr(IBPC_ADDR_LOC, 8'h00);
      wr(IBPC_ADDR_ALARM, 8'h00);
      rd(IBPC_ADDR_LOC, 8'h00);
      rd(IBPC_ADDR_ALARM, 8'h00);
      stream(2, mask);
      rd(IBPC_ADDR_LOC, mask);
      rd(IBPC_ADDR_ALARM, 8'h08);
      // key register changed between runs while the source keeps sending the old key: compare must follow the register
      rnd = lfsr(mask);
      wr(IBPC_ADDR_KEY0 + 5'h03, rnd);
      wr(IBPC_ADDR_LOC, 8'h00);
      stream(2, 8'h00);
      want    = key;
      want[3] = rnd;
      rd(IBPC_ADDR_LOC, exp_loc(key, want));
      // only bit three of the alarm register is writable
      wr(IBPC_ADDR_ALARM, 8'hF7);
      rd(IBPC_ADDR_ALARM, 8'h00);
      // enable after the marker has passed: bad words must stay unchecked
      wr(IBPC_ADDR_CTRL, 8'h00);
      wr(IBPC_ADDR_LOC, 8'h00);
      @(posedge clk_i);
      flip <= mask;
      run  <= 1'b1;
      repeat (24) @(posedge clk_i);
      wr(IBPC_ADDR_CTRL, 8'h01);
      repeat (64) @(posedge clk_i);
      run <= 1'b0;
      repeat (24) @(posedge clk_i);
      rd(IBPC_ADDR_LOC, 8'h00);
      rd(IBPC_ADDR_ALARM, 8'h00);
      wr(IBPC_ADDR_CTRL, 8'h00);
      #1 cmp("analog", 8'h01, {7'h00, analog_active});
      @(posedge clk_i);
      tx_en <= 1'b0;
      #1 cmp("analog", 8'h00, {7'h00, analog_active});
      // second reset: written registers fall back to their reset values
      @(posedge clk_i);
      rst_b_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      rst_b_i <= 1'b1;
      rd(IBPC_ADDR_KEY0, IBPC_KEY0_RST);
      rd(IBPC_ADDR_KEY0 + 5'h03, IBPC_KEYN_RST);
      rd(IBPC_ADDR_LOC, IBPC_LOC_RST);
      cmp("alarm", 8'h00, {7'h00, iface_alarm});
      give_verdict();
   end
endmodule
